/* File: src/pwm_regs_map.vh */
// register indices, field positions and reset values of the triple pwm block
`ifndef PWM_REGS_MAP_VH
`define PWM_REGS_MAP_VH
// register indices; byte address on the bus is four times the index
`define IDX_PWM1_MODE 8'hab
`define IDX_PWM2_MODE 8'ha1
`define IDX_PWM3_MODE 8'hb1
`define IDX_PWM1_PERIOD_LOW 8'hac
`define IDX_PWM1_PERIOD_HIGH 8'had
`define IDX_PWM2_PERIOD_LOW 8'ha2
`define IDX_PWM2_PERIOD_HIGH 8'ha3
`define IDX_PWM3_PERIOD_LOW 8'hb2
`define IDX_PWM3_PERIOD_HIGH 8'hb3
`define IDX_PWM1_DUTY_LOW 8'hbb
`define IDX_PWM1_DUTY_HIGH 8'hbc
`define IDX_PWM2_DUTY_LOW 8'ha6
`define IDX_PWM2_DUTY_HIGH 8'ha7
`define IDX_PWM3_DUTY_LOW 8'h86
`define IDX_PWM3_DUTY_HIGH 8'h87
`define IDX_PWM1_LONG_DB_LOW 8'hae
`define IDX_PWM1_LONG_DB_HIGH 8'haf
`define IDX_PWM2_LONG_DB_LOW 8'ha4
`define IDX_PWM2_LONG_DB_HIGH 8'ha5
`define IDX_PWM3_LONG_DB_LOW 8'hb4
`define IDX_PWM3_LONG_DB_HIGH 8'hb5
`define IDX_PWM1_SHORT_DB 8'hbd
`define IDX_PWM2_SHORT_DB 8'hbe
`define IDX_PWM3_SHORT_DB 8'hcf
`define IDX_COMPARATOR_SYNC 8'h9b
`define IDX_GEN_ENABLE_PIN_CTRL 8'he4
`define IDX_IRQ_ENABLE_GROUP0 8'ha8
`define IDX_IRQ_ENABLE_GROUP2 8'h9a
`define IDX_IRQ_ENABLE_GROUP4 8'hd1
`define IDX_IRQ_FLAGS_GROUP2 8'hbf
// mode register fields
`define MODE_RATE_MSB 7
`define MODE_RATE_LSB 5
`define MODE_SECOND_INVERT_BIT 4
`define MODE_FIRST_INVERT_BIT 3
`define MODE_SECOND_PIN_SELECT_BIT 2
`define MODE_FIRST_PIN_SELECT_BIT 1
`define MODE_ONE_PULSE_BIT 0
// enable and interrupt fields
`define GEN1_ENABLE_BIT 5
`define GEN2_ENABLE_BIT 6
`define GEN3_ENABLE_BIT 7
`define GLOBAL_IRQ_ENABLE_BIT 7
`define GEN1_IRQ_ENABLE_BIT 7
`define GEN1_IRQ_FLAG_BIT 3
`define GEN2_IRQ_ENABLE_BIT 1
`define GEN3_IRQ_ENABLE_BIT 2
`define GEN2_IRQ_FLAG_BIT 0
`define GEN3_IRQ_FLAG_BIT 1
// reset values
`define RESET_BYTE 8'h00
`define RESET_WORD 16'h0000
// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

/* File: src/pwm_generator.v */
// one 16-bit pwm generator with prescaler, dead band and two shared pins
`timescale 1ns/1ps
module pwm_generator (
  input wire aclk, // system clock
  input wire aresetn, // synchronous reset, active low
  input wire generator_enable, // generator runs while high
  input wire [7:0] mode, // mode register contents
  input wire [15:0] period_value, // cycle length
  input wire [15:0] duty_value, // high time
  input wire [15:0] long_deadband_value, // trimmed off the falling edge
  input wire [7:0] short_deadband_value, // trimmed off the rising edge
  input wire [1:0] gpio_level, // level the general-purpose side drives
  output reg [1:0] pin_out, // first and second output pin
  output wire overflow, // one-cycle pulse at end of cycle
  output wire pulse_done // one-cycle pulse at end of a single pulse
);
`include "pwm_regs_map.vh"

  reg [6:0] prescale; // free-running divider of the oscillator
  reg [15:0] cycle_counter; // up counter of the pwm cycle
  reg synced; // output handed over on the first tick after enable
  reg wave; // pwm waveform before inversion
  wire tick; // one-cycle enable at the selected rate
  wire [15:0] count_plus; // counter plus one
  wire [16:0] window_end; // duty minus long dead band, with borrow
  wire no_pulse; // dead band swallows the whole high time
  wire next_wave; // waveform for the present count
  integer i;

  // mask of prescaler bits that must be all ones for a tick
  function [6:0] rate_mask;
    input [2:0] rate;
    begin
      rate_mask = 7'h7f >> rate;
    end
  endfunction

  assign tick = (prescale & rate_mask(mode[`MODE_RATE_MSB:`MODE_RATE_LSB])) ==
    rate_mask(mode[`MODE_RATE_MSB:`MODE_RATE_LSB]);
  assign count_plus = cycle_counter + 16'h0001;
  // cycle ends as the counter would step from period-1 to period
  assign overflow = generator_enable & tick & (count_plus == period_value);
  assign pulse_done = overflow & mode[`MODE_ONE_PULSE_BIT];
  assign window_end = {1'b0, duty_value} - {1'b0, long_deadband_value};
  // borrow or a short band reaching the end leaves nothing to drive
  assign no_pulse = window_end[16] | ({8'h00, short_deadband_value} >= window_end[15:0]);
  // high from the count equal to the short band until the count reaches duty minus the long band
  assign next_wave = ~no_pulse & ({8'h00, short_deadband_value} <= cycle_counter) &
    (cycle_counter < window_end[15:0]);

  // prescaler runs always so the rate change needs no restart
  always @(posedge aclk)
  begin
    if (!aresetn)
      prescale <= 7'h00;
    else
      prescale <= prescale + 7'h01;
  end

  // cycle counter: held at zero while disabled, one step per tick
  always @(posedge aclk)
  begin
    if (!aresetn)
      cycle_counter <= `RESET_WORD;
    else if (!generator_enable)
      cycle_counter <= `RESET_WORD;
    else if (tick)
    begin
      if (count_plus == period_value)
        cycle_counter <= `RESET_WORD;
      else
        cycle_counter <= count_plus;
    end
  end

  // output synchronisation completes at the first tick after enable
  always @(posedge aclk)
  begin
    if (!aresetn)
      synced <= 1'b0;
    else if (!generator_enable)
      synced <= 1'b0;
    else if (tick)
      synced <= 1'b1;
  end

  // registered waveform
  always @(posedge aclk)
  begin
    if (!aresetn)
      wave <= 1'b0;
    else
      wave <= next_wave;
  end

  // pin mux: pwm only when enabled, synced and selected, else gpio level
  always @(posedge aclk)
  begin
    if (!aresetn)
      pin_out <= 2'b00;
    else
      for (i = 0; i < 2; i = i + 1)
      begin
        if (generator_enable && synced && mode[`MODE_FIRST_PIN_SELECT_BIT + i])
          pin_out[i] <= wave ^ mode[`MODE_FIRST_INVERT_BIT + i];
        else
          pin_out[i] <= gpio_level[i];
      end
  end

endmodule // pwm_generator

/* File: src/triple_pwm_generator.v */
// three pwm generators behind an axi4-lite register slave
`timescale 1ns/1ps
module triple_pwm_generator (
  input wire aclk, // system clock, 25 MHz
  input wire aresetn, // synchronous reset, active low
  input wire [9:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output wire s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // write byte strobes
  input wire s_axi_wvalid, // write data valid
  output wire s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [9:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output wire s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [5:0] gpio_level, // gpio levels, two per generator
  output wire [5:0] pin_out, // shared output pins, two per generator
  output wire [2:0] irq_request, // per generator request, flag and enable
  output wire wake_request // any enabled overflow request
);
`include "pwm_regs_map.vh"

  reg [7:0] mode [0:2]; // mode registers
  reg [15:0] period_value [0:2]; // period per generator
  reg [15:0] duty_value [0:2]; // duty per generator
  reg [15:0] long_deadband_value [0:2]; // long dead band per generator
  reg [7:0] short_deadband_value [0:2]; // short dead band per generator
  reg [2:0] generator_enable; // enable per generator
  reg [5:0] comparator_sync; // stored only, no effect on the waveform
  reg global_irq_enable; // stored for the interrupt controller
  reg [2:0] overflow_irq_enable; // per generator gate
  reg [2:0] overflow_irq_flag; // sticky overflow flags
  reg aw_held; // write address captured
  reg [9:0] aw_addr_q; // captured write address
  reg w_held; // write data captured
  reg [7:0] w_byte_q; // captured low data byte
  reg w_strb_q; // captured lane-0 strobe
  reg [7:0] read_byte; // read mux output
  wire [2:0] overflow; // overflow pulses
  wire [2:0] pulse_done; // single pulse finished
  wire do_write; // write commits this cycle
  wire wr_ok; // write hits a mapped, aligned register
  wire wr_en; // write changes storage
  wire [7:0] wr_idx; // write register index
  wire [7:0] rd_idx; // read register index
  wire [7:0] next_enable_written; // enable byte from a write
  wire en_write; // write to the enable register
  wire [7:0] wb; // written byte

  // true for every register index that the block answers
  function is_mapped;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_PWM1_MODE, `IDX_PWM2_MODE, `IDX_PWM3_MODE,
        `IDX_PWM1_PERIOD_LOW, `IDX_PWM1_PERIOD_HIGH,
        `IDX_PWM2_PERIOD_LOW, `IDX_PWM2_PERIOD_HIGH,
        `IDX_PWM3_PERIOD_LOW, `IDX_PWM3_PERIOD_HIGH,
        `IDX_PWM1_DUTY_LOW, `IDX_PWM1_DUTY_HIGH,
        `IDX_PWM2_DUTY_LOW, `IDX_PWM2_DUTY_HIGH,
        `IDX_PWM3_DUTY_LOW, `IDX_PWM3_DUTY_HIGH,
        `IDX_PWM1_LONG_DB_LOW, `IDX_PWM1_LONG_DB_HIGH,
        `IDX_PWM2_LONG_DB_LOW, `IDX_PWM2_LONG_DB_HIGH,
        `IDX_PWM3_LONG_DB_LOW, `IDX_PWM3_LONG_DB_HIGH,
        `IDX_PWM1_SHORT_DB, `IDX_PWM2_SHORT_DB, `IDX_PWM3_SHORT_DB,
        `IDX_COMPARATOR_SYNC, `IDX_GEN_ENABLE_PIN_CTRL,
        `IDX_IRQ_ENABLE_GROUP0, `IDX_IRQ_ENABLE_GROUP2,
        `IDX_IRQ_ENABLE_GROUP4, `IDX_IRQ_FLAGS_GROUP2:
          is_mapped = 1'b1;
        default:
          is_mapped = 1'b0;
      endcase
    end
  endfunction

  // the three generators
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : gen
      pwm_generator u_gen (
        .aclk(aclk),
        .aresetn(aresetn),
        .generator_enable(generator_enable[g]),
        .mode(mode[g]),
        .period_value(period_value[g]),
        .duty_value(duty_value[g]),
        .long_deadband_value(long_deadband_value[g]),
        .short_deadband_value(short_deadband_value[g]),
        .gpio_level(gpio_level[2*g+1:2*g]),
        .pin_out(pin_out[2*g+1:2*g]),
        .overflow(overflow[g]),
        .pulse_done(pulse_done[g])
      );
    end
  endgenerate

  // request lines; the interrupt controller itself lives elsewhere
  assign irq_request = overflow_irq_flag & overflow_irq_enable;
  assign wake_request = |irq_request;

  // bus handshakes: one capture slot per channel, held until the write commits
  assign s_axi_awready = ~aw_held;
  assign s_axi_wready = ~w_held;
  assign s_axi_arready = ~s_axi_rvalid;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  assign wr_idx = aw_addr_q[9:2];
  assign rd_idx = s_axi_araddr[9:2];
  assign wr_ok = (aw_addr_q[1:0] == 2'b00) & is_mapped(wr_idx);
  // only lane 0 carries data; other lanes are ignored
  assign wr_en = do_write & wr_ok & w_strb_q;
  assign wb = w_byte_q;
  assign en_write = wr_en & (wr_idx == `IDX_GEN_ENABLE_PIN_CTRL);
  assign next_enable_written = wb;

  // capture address and data in either order
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr_q <= 10'h000;
      w_held <= 1'b0;
      w_byte_q <= `RESET_BYTE;
      w_strb_q <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_held)
      begin
        aw_held <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      else if (do_write)
        aw_held <= 1'b0;
      if (s_axi_wvalid && !w_held)
      begin
        w_held <= 1'b1;
        w_byte_q <= s_axi_wdata[7:0];
        w_strb_q <= s_axi_wstrb[0];
      end
      else if (do_write)
        w_held <= 1'b0;
    end
  end

  // write response; unmapped or misaligned addresses answer slverr
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end
    else if (do_write)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // byte registers of the three generators, comparator sync and interrupt enables
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode[0] <= `RESET_BYTE;
      mode[1] <= `RESET_BYTE;
      mode[2] <= `RESET_BYTE;
      period_value[0] <= `RESET_WORD;
      period_value[1] <= `RESET_WORD;
      period_value[2] <= `RESET_WORD;
      duty_value[0] <= `RESET_WORD;
      duty_value[1] <= `RESET_WORD;
      duty_value[2] <= `RESET_WORD;
      long_deadband_value[0] <= `RESET_WORD;
      long_deadband_value[1] <= `RESET_WORD;
      long_deadband_value[2] <= `RESET_WORD;
      short_deadband_value[0] <= `RESET_BYTE;
      short_deadband_value[1] <= `RESET_BYTE;
      short_deadband_value[2] <= `RESET_BYTE;
      comparator_sync <= 6'h00;
      global_irq_enable <= 1'b0;
      overflow_irq_enable <= 3'h0;
    end
    else if (wr_en)
    begin
      case (wr_idx)
        `IDX_PWM1_MODE: mode[0] <= wb;
        `IDX_PWM2_MODE: mode[1] <= wb;
        `IDX_PWM3_MODE: mode[2] <= wb;
        `IDX_PWM1_PERIOD_LOW: period_value[0][7:0] <= wb;
        `IDX_PWM1_PERIOD_HIGH: period_value[0][15:8] <= wb;
        `IDX_PWM2_PERIOD_LOW: period_value[1][7:0] <= wb;
        `IDX_PWM2_PERIOD_HIGH: period_value[1][15:8] <= wb;
        `IDX_PWM3_PERIOD_LOW: period_value[2][7:0] <= wb;
        `IDX_PWM3_PERIOD_HIGH: period_value[2][15:8] <= wb;
        `IDX_PWM1_DUTY_LOW: duty_value[0][7:0] <= wb;
        `IDX_PWM1_DUTY_HIGH: duty_value[0][15:8] <= wb;
        `IDX_PWM2_DUTY_LOW: duty_value[1][7:0] <= wb;
        `IDX_PWM2_DUTY_HIGH: duty_value[1][15:8] <= wb;
        `IDX_PWM3_DUTY_LOW: duty_value[2][7:0] <= wb;
        `IDX_PWM3_DUTY_HIGH: duty_value[2][15:8] <= wb;
        `IDX_PWM1_LONG_DB_LOW: long_deadband_value[0][7:0] <= wb;
        `IDX_PWM1_LONG_DB_HIGH: long_deadband_value[0][15:8] <= wb;
        `IDX_PWM2_LONG_DB_LOW: long_deadband_value[1][7:0] <= wb;
        `IDX_PWM2_LONG_DB_HIGH: long_deadband_value[1][15:8] <= wb;
        `IDX_PWM3_LONG_DB_LOW: long_deadband_value[2][7:0] <= wb;
        `IDX_PWM3_LONG_DB_HIGH: long_deadband_value[2][15:8] <= wb;
        `IDX_PWM1_SHORT_DB: short_deadband_value[0] <= wb;
        `IDX_PWM2_SHORT_DB: short_deadband_value[1] <= wb;
        `IDX_PWM3_SHORT_DB: short_deadband_value[2] <= wb;
        `IDX_COMPARATOR_SYNC: comparator_sync <= wb[7:2];
        `IDX_IRQ_ENABLE_GROUP0: global_irq_enable <= wb[`GLOBAL_IRQ_ENABLE_BIT];
        `IDX_IRQ_ENABLE_GROUP2:
        begin
          overflow_irq_enable[1] <= wb[`GEN2_IRQ_ENABLE_BIT];
          overflow_irq_enable[2] <= wb[`GEN3_IRQ_ENABLE_BIT];
        end
        `IDX_IRQ_ENABLE_GROUP4: overflow_irq_enable[0] <= wb[`GEN1_IRQ_ENABLE_BIT];
        default: global_irq_enable <= global_irq_enable;
      endcase
    end
  end

  // enables: a software write wins over the hardware clear at pulse end
  always @(posedge aclk)
  begin
    if (!aresetn)
      generator_enable <= 3'h0;
    else if (en_write)
    begin
      generator_enable[0] <= next_enable_written[`GEN1_ENABLE_BIT];
      generator_enable[1] <= next_enable_written[`GEN2_ENABLE_BIT];
      generator_enable[2] <= next_enable_written[`GEN3_ENABLE_BIT];
    end
    else
      generator_enable <= generator_enable & ~pulse_done;
  end

  // sticky flags: software may write them, an overflow in the same cycle wins
  always @(posedge aclk)
  begin
    if (!aresetn)
      overflow_irq_flag <= 3'h0;
    else if (wr_en && wr_idx == `IDX_IRQ_ENABLE_GROUP4)
      overflow_irq_flag <= {overflow_irq_flag[2:1],
        wb[`GEN1_IRQ_FLAG_BIT]} | overflow;
    else if (wr_en && wr_idx == `IDX_IRQ_FLAGS_GROUP2)
      overflow_irq_flag <= {wb[`GEN3_IRQ_FLAG_BIT], wb[`GEN2_IRQ_FLAG_BIT],
        overflow_irq_flag[0]} | overflow;
    else
      overflow_irq_flag <= overflow_irq_flag | overflow;
  end

  // read mux; unlisted bits read zero
  always @*
  begin
    read_byte = `RESET_BYTE;
    case (rd_idx)
      `IDX_PWM1_MODE: read_byte = mode[0];
      `IDX_PWM2_MODE: read_byte = mode[1];
      `IDX_PWM3_MODE: read_byte = mode[2];
      `IDX_PWM1_PERIOD_LOW: read_byte = period_value[0][7:0];
      `IDX_PWM1_PERIOD_HIGH: read_byte = period_value[0][15:8];
      `IDX_PWM2_PERIOD_LOW: read_byte = period_value[1][7:0];
      `IDX_PWM2_PERIOD_HIGH: read_byte = period_value[1][15:8];
      `IDX_PWM3_PERIOD_LOW: read_byte = period_value[2][7:0];
      `IDX_PWM3_PERIOD_HIGH: read_byte = period_value[2][15:8];
      `IDX_PWM1_DUTY_LOW: read_byte = duty_value[0][7:0];
      `IDX_PWM1_DUTY_HIGH: read_byte = duty_value[0][15:8];
      `IDX_PWM2_DUTY_LOW: read_byte = duty_value[1][7:0];
      `IDX_PWM2_DUTY_HIGH: read_byte = duty_value[1][15:8];
      `IDX_PWM3_DUTY_LOW: read_byte = duty_value[2][7:0];
      `IDX_PWM3_DUTY_HIGH: read_byte = duty_value[2][15:8];
      `IDX_PWM1_LONG_DB_LOW: read_byte = long_deadband_value[0][7:0];
      `IDX_PWM1_LONG_DB_HIGH: read_byte = long_deadband_value[0][15:8];
      `IDX_PWM2_LONG_DB_LOW: read_byte = long_deadband_value[1][7:0];
      `IDX_PWM2_LONG_DB_HIGH: read_byte = long_deadband_value[1][15:8];
      `IDX_PWM3_LONG_DB_LOW: read_byte = long_deadband_value[2][7:0];
      `IDX_PWM3_LONG_DB_HIGH: read_byte = long_deadband_value[2][15:8];
      `IDX_PWM1_SHORT_DB: read_byte = short_deadband_value[0];
      `IDX_PWM2_SHORT_DB: read_byte = short_deadband_value[1];
      `IDX_PWM3_SHORT_DB: read_byte = short_deadband_value[2];
      `IDX_COMPARATOR_SYNC: read_byte = {comparator_sync, 2'b00};
      `IDX_GEN_ENABLE_PIN_CTRL: read_byte = {generator_enable, 5'h00};
      `IDX_IRQ_ENABLE_GROUP0: read_byte = {global_irq_enable, 7'h00};
      `IDX_IRQ_ENABLE_GROUP2: read_byte = {5'h00, overflow_irq_enable[2:1], 1'b0};
      `IDX_IRQ_ENABLE_GROUP4: read_byte = {overflow_irq_enable[0], 3'h0,
        overflow_irq_flag[0], 3'h0};
      `IDX_IRQ_FLAGS_GROUP2: read_byte = {6'h00, overflow_irq_flag[2:1]};
      default: read_byte = `RESET_BYTE;
    endcase
  end

  // read channel: data one cycle after the address is taken
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      if (s_axi_araddr[1:0] == 2'b00 && is_mapped(rd_idx))
      begin
        s_axi_rdata <= {24'h000000, read_byte};
        s_axi_rresp <= `RESP_OKAY;
      end
      else
      begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `RESP_SLVERR;
      end
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule // triple_pwm_generator

/* File: dv/triple_pwm_generator_sva.sv */
// bus and request checks on the ports of the triple pwm block
`timescale 1ns/1ps
module triple_pwm_generator_sva (
  input wire aclk, // clock
  input wire aresetn, // reset, active low
  input wire s_axi_awvalid, // write address valid
  input wire s_axi_awready, // write address ready
  input wire s_axi_wvalid, // write data valid
  input wire s_axi_wready, // write data ready
  input wire [1:0] s_axi_bresp, // write response
  input wire s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire s_axi_arvalid, // read address valid
  input wire s_axi_arready, // read address ready
  input wire [31:0] s_axi_rdata, // read data
  input wire s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [2:0] irq_request, // request per generator
  input wire wake_request // wake from idle
);
  // one domain, so clock and reset are given once
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // address and data offered and taken in the same cycle
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped early");
  a_read_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while answer stands");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
  a_wake_follows_irq: assert property (wake_request == (|irq_request))
    else $error("wake differs from requests");
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
    && irq_request == 3'h0) else $error("state left after reset");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_answer: assert property (s_wr_taken && !s_axi_bvalid |=> ##1 s_axi_bvalid)
    else $error("write not answered two cycles after capture");
endmodule // triple_pwm_generator_sva
bind triple_pwm_generator triple_pwm_generator_sva i_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_request,
  .wake_request);

/* File: dv/pwm_load_model.sv */
// load on the output pins: counts the cycles each pin spends high
`timescale 1ns/1ps
module pwm_load_model (
  input wire aclk, // clock
  input wire measure, // counting window
  input wire [5:0] pin_out, // pins under load
  output logic [47:0] highs // high cycles per pin, 8 bits each
);
  // counts clear outside the window so each window starts fresh
  always @(posedge aclk)
  begin
    for (int k = 0; k < 6; k++)
      highs[k*8+:8] <= measure ? highs[k*8+:8] + pin_out[k] : 8'h00;
  end
endmodule // pwm_load_model

/* File: dv/tb.sv */
// self-checking bench for the triple pwm generator
`timescale 1ns/1ps
module tb;
  logic aclk = 0; // 25 MHz
  logic aresetn = 0; // active low
  logic [9:0] awa = 0, ara = 0; // byte addresses
  logic awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, meas = 0; // handshakes, window
  logic [31:0] wd = 0; // write data
  logic [5:0] gpio = 0; // gpio side levels
  logic [7:0] seed = 8'h3c, d; // lfsr state, read byte
  logic [1:0] r, q; // read and write responses
  logic [7:0] ix [15] = '{8'hac, 8'had, 8'ha2, 8'ha3, 8'hb2, 8'hb3, 8'hbb, 8'hbc,
    8'ha6, 8'ha7, 8'h86, 8'h87, 8'hab, 8'ha1, 8'hb1}; // period, duty, mode
  wire awr, wrd, arr, bv, rv, wake; // slave answers
  wire [1:0] br, rr; // responses
  wire [31:0] rdat; // read data
  wire [5:0] pins; // output pins
  wire [2:0] irq; // requests
  wire [47:0] highs; // load counts
  int n_errors = 0, check_count = 0, n, hold = 0; // counters, cycles ready is held back
  initial forever #20 aclk = ~aclk;
  triple_pwm_generator i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv),
    .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
    .gpio_level(gpio), .pin_out(pins), .irq_request(irq), .wake_request(wake));
  pwm_load_model i_load (.aclk(aclk), .measure(meas), .pin_out(pins), .highs(highs));
  // high cycles in one period for a window [short, duty-long)
  function int hc(input int p, input int dt, input int s, input int l);
    hc = 0;
    for (int c = 0; c < p; c++)
      if (c >= s && c < dt - l) hc++;
  endfunction
  function logic [7:0] nx(input logic [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task stop_test;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      n_errors++;
    end
  endtask
  // handshakes are judged mid-cycle, released right after the taking edge
  task wr(input logic [7:0] i, input logic [7:0] v);
    int t;
    logic a, w, b, dn;
    @(posedge aclk);
    awa <= {i, 2'b00}; wd <= {24'h0, v}; awv <= 1; wv <= 1; bre <= (hold == 0); dn = 0;
    for (t = 0; t < 50 && !dn; t++)
    begin
      @(negedge aclk); a = awv && awr; w = wv && wrd; b = bv && bre; q = br;
      @(posedge aclk); if (a) awv <= 0; if (w) wv <= 0;
      if (b) begin bre <= 0; dn = 1; end else if (t + 1 == hold) bre <= 1;
    end
    if (!dn) begin n_errors++; stop_test; end
  endtask
  task rd(input logic [7:0] i, output logic [7:0] v, output logic [1:0] rs);
    int t;
    logic a, b, dn;
    @(posedge aclk);
    ara <= {i, 2'b00}; arv <= 1; rre <= (hold == 0); dn = 0;
    for (t = 0; t < 50 && !dn; t++)
    begin
      @(negedge aclk); a = arv && arr; b = rv && rre; v = rdat[7:0]; rs = rr;
      @(posedge aclk); if (a) arv <= 0;
      if (b) begin rre <= 0; dn = 1; end else if (t + 1 == hold) rre <= 1;
    end
    if (!dn) begin n_errors++; stop_test; end
  endtask
  // let the output settle, then count highs over n cycles
  task pm(input int c);
    repeat (10) @(posedge aclk);
    meas <= 1;
    repeat (c) @(posedge aclk);
    meas <= 0;
    @(negedge aclk);
  endtask
  task wt(input int k, input logic lv);
    int t;
    @(negedge aclk);
    for (t = 0; t < 600 && pins[k] !== lv; t++) @(negedge aclk);
    if (t == 600) begin n_errors++; stop_test; end
  endtask
  initial
  begin
    repeat (10) @(posedge aclk);
    seed = nx(seed);
    gpio <= seed[5:0];
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    @(negedge aclk); chk(pins, gpio);
    foreach (ix[k]) begin rd(ix[k], d, r); chk(d, 0); end
    rd(8'h00, d, r); chk(r, 2'b10);
    wr(8'h00, 8'h55); chk(q, 2'b10);
    // answers left standing while ready is held back; this short band is set again later
    hold = 3; wr(8'hcf, 8'h5a); chk(q, 2'b00);
    rd(8'hcf, d, r); chk(d, 8'h5a); chk(r, 2'b00); hold = 0;
    foreach (ix[k]) begin seed = nx(seed); wr(ix[k], seed); rd(ix[k], d, r); chk(d, seed); end
    // continuous run, second channel inverted; duty kept below period
    wr(8'hac, 4); wr(8'had, 0); wr(8'hbb, 1); wr(8'hbc, 0); wr(8'hab, 8'hf6); wr(8'he4, 8'h20);
    pm(16); chk(highs[7:0], 4 * hc(4, 1, 0, 0));
    chk(highs[15:8], 16 - 4 * hc(4, 1, 0, 0));
    rd(8'hd1, d, r); chk(d[3], 1);
    wr(8'he4, 0); repeat (3) @(posedge aclk);
    @(negedge aclk); chk(pins[1:0], gpio[1:0]);
    // every rate code on generator two, high phase of one count
    wr(8'ha2, 2); wr(8'ha3, 0); wr(8'ha6, 1); wr(8'ha7, 0); wr(8'he4, 8'h40);
    for (int c = 0; c < 8; c++)
    begin
      wr(8'ha1, {c[2:0], 5'h02}); wt(2, 1); wt(2, 0); wt(2, 1);
      for (n = 0; n < 600 && pins[2] === 1'b1; n++) @(negedge aclk);
      chk(n, 128 >> c);
    end
    wr(8'he4, 0);
    // dead band on generator three, then a band too long
    wr(8'hb2, 8); wr(8'hb3, 0); wr(8'h86, 6); wr(8'h87, 0); wr(8'hcf, 2); wr(8'hb4, 1);
    wr(8'hb5, 0); wr(8'hb1, 8'he2); wr(8'he4, 8'h80);
    pm(16); chk(highs[39:32], 2 * hc(8, 6, 2, 1));
    wr(8'hb4, 7); pm(16); chk(highs[39:32], 2 * hc(8, 6, 2, 7));
    wr(8'he4, 0);
    // one pulse, twice, with the request enabled
    gpio <= 6'h00;
    wr(8'hd1, 8'h80); wr(8'hab, 8'he3);
    @(negedge aclk); chk(irq[0], 0);
    meas <= 1;
    repeat (2)
    begin
      wr(8'he4, 8'h20);
      d = 8'h01;
      for (n = 0; n < 20 && d !== 8'h00; n++) rd(8'he4, d, r);
      chk(d, 0);
    end
    repeat (4) @(posedge aclk);
    meas <= 0;
    @(negedge aclk); chk(highs[7:0], 2 * hc(4, 1, 0, 0));
    chk(pins[0], gpio[0]);
    rd(8'hd1, d, r); chk(d, 8'h88);
    chk(irq, 3'h1); chk(wake, 1);
    wr(8'hd1, 8'h80);
    @(negedge aclk); chk(irq, 0);
    stop_test;
  end
endmodule // tb
